/* File: hdl/e1_tx_cfg.svh */
// Purpose: Constants for the E1 transmit input and signal-loss block.
// Assumes: core_clk at 200 MHz, transmit bit clock near 2.048 MHz.
// Notes:   Times in their own unit, RZ entry cycle count derived from them; CLK_GONE_CYCLES set in cycles.
`ifndef E1_TX_CFG_SVH
`define E1_TX_CFG_SVH

`define CORE_CLK_MHZ        200
`define RZ_ENTRY_TIME_NS    12000
`define RZ_ENTRY_CYCLES     ((`RZ_ENTRY_TIME_NS * `CORE_CLK_MHZ + 999) / 1000)
`define UNIPOLAR_MIN_BITS   16
`define CLK_GONE_CYCLES     256
`define LOS_ZEROS_ITU       32
`define LOS_ONES_ITU        32
`define LOS_ZEROS_ETSI      2048
`define LOS_ONES_ETSI       2048
`define LOS_RESET_VALUE     1'b1
`define TX_FIFO_DEPTH       32
`define TX_FIFO_WIDTH       2

`endif

/* File: hdl/e1_tx_input.sv */
// Purpose: Transmit input decoding and signal-loss status for one E1 channel.
// Assumes: Bit clock domain drives sampling; core_clk runs the line side.
// Notes:   Line pulses are core-clock levels; analog drivers sit outside.
// Function
// - Signal-loss output high during loss, standard selectable
// - Loss clears after signal present for required time
// - Bipolar: sample inputs on falling bit clock
// - Positive input gives positive pulse, negative negative
// - Bit clock high 12 us, no master: RZ
// - RZ pulse width follows input pulse width
// - Bit clock held low: drivers high impedance
// - Pin meaning follows active input mode
// - Select high over 16 bits with master clock present: unipolar mode
`include "e1_tx_cfg.svh"

module e1_tx_input
	import e1_tx_pkg::*;
#(
	parameter int RZ_ENTRY_CYCLES = `RZ_ENTRY_CYCLES,
	parameter int LOS_ZEROS_ETSI  = `LOS_ZEROS_ETSI,
	parameter int LOS_ONES_ETSI   = `LOS_ONES_ETSI
) (
	input  wire logic core_clk,
	input  wire logic rstn,
	input  wire logic tx_bit_clock_in,
	input  wire logic tx_positive_pulse_in,
	input  wire logic tx_negative_pulse_in,
	input  wire logic master_clock_present,
	input  wire logic los_standard_etsi,
	input  wire logic rx_pulse_in,
	output logic      signal_loss_out,
	output logic      line_tx_tip,
	output logic      line_tx_ring,
	output logic      line_tx_oe_n,
	output logic [1:0] input_mode_out
);

	// Bit-clock domain: sample pins on falling edge
	logic         pos_fall_reg;
	logic         neg_fall_reg;
	logic [4:0]   ubs_run_reg;
	logic [4:0]   ubs_run_next;
	logic         unipolar_reg;
	logic         unipolar_next;

	always_comb begin
		ubs_run_next    = ubs_run_reg;
		unipolar_next   = unipolar_reg;
		if (!tx_negative_pulse_in) begin
			ubs_run_next  = '0;
			unipolar_next = 1'b0;
		end else if (ubs_run_reg != 5'h1F) begin
			ubs_run_next = ubs_run_reg + 5'h01;
		end
		if (ubs_run_reg >= 5'(`UNIPOLAR_MIN_BITS)) begin
			unipolar_next = 1'b1;
		end
	end

	// No reset here: bit clock may be stopped while rstn is applied
	// Held pins and the unipolar flag; the core side reads the pins after a synced edge, the flag through a synchroniser
	always_ff @(negedge tx_bit_clock_in) begin
		pos_fall_reg   <= tx_positive_pulse_in;
		neg_fall_reg   <= tx_negative_pulse_in;
		ubs_run_reg    <= ubs_run_next;
		unipolar_reg   <= unipolar_next;
	end

	// Two-stage synchronisers into core_clk
	// Only the second stage of each pair feeds logic
	logic [1:0] clk_sync_reg;
	logic [1:0] std_sync_reg;
	logic [1:0] uni_sync_reg;
	logic [1:0] pos_sync_reg;
	logic [1:0] neg_sync_reg;
	logic [1:0] mclk_sync_reg;
	logic [1:0] rx_sync_reg;
	logic       clk_seen_reg;

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			clk_sync_reg  <= '0;
			std_sync_reg  <= '0;
			uni_sync_reg  <= '0;
			pos_sync_reg  <= '0;
			neg_sync_reg  <= '0;
			mclk_sync_reg <= '0;
			rx_sync_reg   <= '0;
			clk_seen_reg  <= 1'b0;
		end else begin
			clk_sync_reg  <= {clk_sync_reg[0], tx_bit_clock_in};
			std_sync_reg  <= {std_sync_reg[0], los_standard_etsi};
			uni_sync_reg  <= {uni_sync_reg[0], unipolar_reg};
			pos_sync_reg  <= {pos_sync_reg[0], tx_positive_pulse_in};
			neg_sync_reg  <= {neg_sync_reg[0], tx_negative_pulse_in};
			mclk_sync_reg <= {mclk_sync_reg[0], master_clock_present};
			rx_sync_reg   <= {rx_sync_reg[0], rx_pulse_in};
			clk_seen_reg  <= clk_sync_reg[1];
		end
	end

	// Synced falling edge of the bit clock marks a new sample
	// Sampled pins hold a whole bit, so a late read is safe
	// Both flops reset low: a clock high at reset gives no edge
	logic sample_evt;
	assign sample_evt = clk_seen_reg & ~clk_sync_reg[1];

	// Static bit clock detection: high run for RZ, low run for high-Z
	localparam int CW = $clog2(RZ_ENTRY_CYCLES + 1);
	logic [CW-1:0] high_cnt_reg;
	logic [CW-1:0] high_cnt_next;
	logic [8:0]    low_cnt_reg;
	logic [8:0]    low_cnt_next;
	input_mode_e   mode_reg;
	input_mode_e   mode_next;
	logic          clk_low_idle;

	// Saturates at the limit, so release holds while the clock stays low
	assign clk_low_idle = (low_cnt_reg == 9'(`CLK_GONE_CYCLES));

	always_comb begin
		high_cnt_next = high_cnt_reg;
		low_cnt_next  = low_cnt_reg;
		// Entry time counts only while the master clock is absent
		if (!clk_sync_reg[1] || mclk_sync_reg[1]) begin
			high_cnt_next = '0;
		end else if (high_cnt_reg != CW'(RZ_ENTRY_CYCLES)) begin
			high_cnt_next = high_cnt_reg + 1'b1;
		end
		if (clk_sync_reg[1]) begin
			low_cnt_next = '0;
		end else if (!clk_low_idle) begin
			low_cnt_next = low_cnt_reg + 9'h001;
		end
		mode_next = mode_reg;
		unique case (mode_reg)
			MODE_BIPOLAR, MODE_UNIPOLAR: begin
				if (high_cnt_reg == CW'(RZ_ENTRY_CYCLES) && !mclk_sync_reg[1]) begin
					mode_next = MODE_RZ;
				end else begin
					mode_next = (uni_sync_reg[1] && mclk_sync_reg[1]) ? MODE_UNIPOLAR : MODE_BIPOLAR;
				end
			end
			MODE_RZ: begin
				// Leave RZ once the bit clock toggles or master clock returns
				if (!clk_sync_reg[1] || mclk_sync_reg[1]) begin
					mode_next = MODE_BIPOLAR;
				end
			end
			default: begin
				mode_next = MODE_BIPOLAR; // Unused code: recover to the safe mode
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			high_cnt_reg <= '0;
			low_cnt_reg  <= '0;
			mode_reg     <= MODE_BIPOLAR;
		end else begin
			high_cnt_reg <= high_cnt_next;
			low_cnt_reg  <= low_cnt_next;
			mode_reg     <= mode_next;
		end
	end

	assign input_mode_out = mode_reg;

	// Decode one sampled bit into a line symbol
	function automatic line_symbol_s decode_symbol(input logic pos, input logic neg,
		input logic uni);
		line_symbol_s s;
		s = '0;
		if (uni) begin
			s.pos = pos; // Unipolar data; line coding lies outside this block
		end else if (pos ^ neg) begin
			s.pos = pos;
			s.neg = neg;
		end
		return s;
	endfunction : decode_symbol

	// Buffer absorbs jitter between bit samples and line output pacing
	line_symbol_s fifo_in;
	line_symbol_s fifo_out;
	logic         fifo_in_ready;
	logic         fifo_out_valid;
	logic         fifo_pop;

	assign fifo_in = decode_symbol(pos_fall_reg, neg_fall_reg, mode_reg == MODE_UNIPOLAR);

	sym_fifo #(
		.WIDTH (`TX_FIFO_WIDTH),
		.DEPTH (`TX_FIFO_DEPTH)
	) u_fifo (
		.core_clk  (core_clk),
		.rstn      (rstn),
		.in_valid  (sample_evt & (mode_reg != MODE_RZ)),
		.in_ready  (fifo_in_ready),
		.in_data   (fifo_in),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_out)
	);

	// One symbol leaves per sample; a full buffer drops the new bit
	assign fifo_pop = fifo_out_valid & sample_evt;

	// Line outputs registered
	logic tip_reg;
	logic tip_next;
	logic ring_reg;
	logic ring_next;
	logic oe_n_reg;
	logic oe_n_next;

	always_comb begin
		tip_next  = tip_reg;
		ring_next = ring_reg;
		oe_n_next = 1'b0;
		if (clk_low_idle) begin
			oe_n_next = 1'b1;
			tip_next  = 1'b0;
			ring_next = 1'b0;
		end else if (mode_reg == MODE_RZ) begin
			// Pulse width tracks the input high time, core-clock granular
			tip_next  = pos_sync_reg[1] & ~neg_sync_reg[1];
			ring_next = neg_sync_reg[1] & ~pos_sync_reg[1];
		end else if (fifo_pop) begin
			tip_next  = fifo_out.pos;
			ring_next = fifo_out.neg;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			tip_reg  <= 1'b0;
			ring_reg <= 1'b0;
			oe_n_reg <= 1'b1;
		end else begin
			tip_reg  <= tip_next;
			ring_reg <= ring_next;
			oe_n_reg <= oe_n_next;
		end
	end

	assign line_tx_tip  = tip_reg;
	assign line_tx_ring = ring_reg;
	assign line_tx_oe_n = oe_n_reg;

	// Signal loss: run of absent pulses sets, run of presence clears
	// Standard select is synchronised; change it only while idle
	logic [11:0] zero_run_reg;
	logic [11:0] zero_run_next;
	logic [11:0] one_run_reg;
	logic [11:0] one_run_next;
	logic        los_reg;
	logic        los_next;
	logic [11:0] zero_lim;
	logic [11:0] one_lim;

	always_comb begin
		zero_lim = std_sync_reg[1] ? 12'(LOS_ZEROS_ETSI) : 12'(`LOS_ZEROS_ITU);
		one_lim  = std_sync_reg[1] ? 12'(LOS_ONES_ETSI) : 12'(`LOS_ONES_ITU);
		zero_run_next = zero_run_reg;
		one_run_next  = one_run_reg;
		los_next      = los_reg;
		if (sample_evt) begin
			if (rx_sync_reg[1]) begin
				zero_run_next = '0;
				if (one_run_reg != 12'hFFF) begin
					one_run_next = one_run_reg + 12'h001;
				end
			end else begin
				one_run_next = '0;
				if (zero_run_reg != 12'hFFF) begin
					zero_run_next = zero_run_reg + 12'h001;
				end
			end
		end
		if (zero_run_reg >= zero_lim) begin
			los_next = 1'b1;
		end else if (one_run_reg >= one_lim) begin
			los_next = 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			zero_run_reg <= '0;
			one_run_reg  <= '0;
			los_reg      <= `LOS_RESET_VALUE;
		end else begin
			zero_run_reg <= zero_run_next;
			one_run_reg  <= one_run_next;
			los_reg      <= los_next;
		end
	end

	assign signal_loss_out = los_reg;

endmodule : e1_tx_input

/* File: hdl/e1_tx_pkg.sv */
// Purpose: Types for the E1 transmit input and signal-loss block.
// Assumes: Constants live in e1_tx_cfg.svh.
// Notes:   Line symbol travels as a packed struct.
package e1_tx_pkg;

	typedef enum logic [1:0] {
		MODE_BIPOLAR,
		MODE_UNIPOLAR,
		MODE_RZ
	} input_mode_e;

	typedef struct packed {
		logic pos;
		logic neg;
	} line_symbol_s;

	typedef enum logic {
		LOS_STD_ITU,
		LOS_STD_ETSI
	} los_std_e;

endpackage : e1_tx_pkg

/* File: hdl/sym_fifo.sv */
// Purpose: Small synchronous FIFO for line symbols.
// Assumes: Single clock, synchronous active-low reset.
// Notes:   Full and empty are exact; no write when full, no read when empty.
module sym_fifo #(
	parameter int WIDTH = 2,
	parameter int DEPTH = 32
) (
	input  wire logic             core_clk,
	input  wire logic             rstn,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    wr_ptr_next;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW-1:0]    rd_ptr_next;
	logic [AW:0]      count_reg;
	logic [AW:0]      count_next;
	logic             push;
	logic             pop;

	// Handshakes from occupancy
	assign in_ready  = (count_reg != (AW+1)'(DEPTH));
	assign out_valid = (count_reg != '0);
	assign out_data  = mem[rd_ptr_reg];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// Pointer and count updates
	always_comb begin
		wr_ptr_next = push ? AW'((wr_ptr_reg + 1'b1) % DEPTH) : wr_ptr_reg;
		rd_ptr_next = pop ? AW'((rd_ptr_reg + 1'b1) % DEPTH) : rd_ptr_reg;
		count_next  = count_reg;
		if (push && !pop) begin
			count_next = count_reg + 1'b1;
		end else if (pop && !push) begin
			count_next = count_reg - 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			wr_ptr_reg <= wr_ptr_next;
			rd_ptr_reg <= rd_ptr_next;
			count_reg  <= count_next;
		end
	end

	// Storage has no reset; only written words are ever read
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data;
		end
	end

endmodule : sym_fifo

/* File: verif/e1_framer_model.sv */
// Purpose: Framer side: bit clock and pulse pins.
// Assumes: 160 ns bit period.
// Notes:   Stopped clock parks; pins then follow sym.
module e1_framer_model
	import e1_tx_pkg::*;
(
	input  wire logic         run,
	input  wire logic         park_hi,
	input  wire line_symbol_s sym,
	output logic              bclk,
	output logic              pos,
	output logic              neg
);
	timeunit 1ns;
	timeprecision 100ps;
	// Odd offset keeps it unrelated to core_clk
	initial begin
		bclk = 1'b0;
		#3;
		forever begin
			#80;
			bclk = run ? !bclk : park_hi;
		end
	end
	// Change after the rising edge, settled for the fall
	line_symbol_s held = '0;
	always @(posedge bclk) if (run) held <= sym;
	// One driver for the pins: latched while running, direct when parked
	assign {pos, neg} = run ? held : sym;
endmodule : e1_framer_model

/* File: verif/e1_tx_input_assertions.sv */
// Purpose: Port checks for the E1 transmit input block.
// Assumes: Bit period of 32 core cycles.
// Notes:   Run-length helpers saturate.
`include "e1_tx_cfg.svh"
module e1_tx_input_checker
	import e1_tx_pkg::*;
#(
	parameter int RZ_ENTRY_CYCLES = 2400,
	parameter int LOS_ZEROS_ETSI  = 2048,
	parameter int LOS_ONES_ETSI   = 2048
) (
	input wire logic       core_clk,
	input wire logic       rstn,
	input wire logic       tx_bit_clock_in,
	input wire logic       tx_positive_pulse_in,
	input wire logic       tx_negative_pulse_in,
	input wire logic       master_clock_present,
	input wire logic       los_standard_etsi,
	input wire logic       rx_pulse_in,
	input wire logic       signal_loss_out,
	input wire logic       line_tx_tip,
	input wire logic       line_tx_ring,
	input wire logic       line_tx_oe_n,
	input wire logic [1:0] input_mode_out
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	logic [15:0] lo_run, hi_run, rx_lo, rx_hi, fall_age, neg_run;
	logic        clk_d;
	logic        fall;
	int          n_set, n_clr;
	assign fall = clk_d && !tx_bit_clock_in;
	assign n_set = los_standard_etsi ? LOS_ZEROS_ETSI : `LOS_ZEROS_ITU;
	assign n_clr = los_standard_etsi ? LOS_ONES_ETSI : `LOS_ONES_ITU;
	function automatic logic [15:0] sat(input logic [15:0] v);
		return v + 16'(v != 16'hFFFF);
	endfunction : sat
	// Reset clears them so they never start unknown
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			{clk_d, lo_run, hi_run, rx_lo, rx_hi, fall_age, neg_run} <= '0;
		end else begin
			clk_d    <= tx_bit_clock_in;
			lo_run   <= tx_bit_clock_in ? '0 : sat(lo_run);
			hi_run   <= (tx_bit_clock_in && !master_clock_present) ? sat(hi_run) : '0;
			rx_lo    <= rx_pulse_in ? '0 : sat(rx_lo);
			rx_hi    <= rx_pulse_in ? sat(rx_hi) : '0;
			fall_age <= fall ? '0 : sat(fall_age);
			neg_run  <= !tx_negative_pulse_in ? '0 : (fall ? sat(neg_run) : neg_run);
		end
	end
	property p_space; input_mode_out != 2'(MODE_RZ) |-> !(line_tx_tip && line_tx_ring); endproperty
	a_space: assert property (p_space) else $error("both pulses high");
	property p_hiz; lo_run >= `CLK_GONE_CYCLES + 8 |-> line_tx_oe_n && !line_tx_tip; endproperty
	a_hiz: assert property (p_hiz) else $error("driver not released");
	property p_los_set; $rose(signal_loss_out) |-> rx_lo >= (n_set - 1) * 32 - 8; endproperty
	a_los_set: assert property (p_los_set) else $error("loss set early");
	property p_los_clr; $fell(signal_loss_out) |-> rx_hi >= (n_clr - 1) * 32 - 8; endproperty
	a_los_clr: assert property (p_los_clr) else $error("loss cleared early");
	property p_bip;
		$changed({line_tx_tip, line_tx_ring}) && !line_tx_oe_n && !$past(line_tx_oe_n)
			&& input_mode_out == 2'(MODE_BIPOLAR) |-> fall_age <= 8;
	endproperty
	a_bip: assert property (p_bip) else $error("symbol off the sample");
	property p_rz; input_mode_out == 2'(MODE_RZ) && $rose(tx_positive_pulse_in) |-> ##[1:4] line_tx_tip; endproperty
	a_rz: assert property (p_rz) else $error("pulse not followed");
	property p_rz_in; $rose(input_mode_out == 2'(MODE_RZ)) |-> hi_run >= RZ_ENTRY_CYCLES; endproperty
	a_rz_in: assert property (p_rz_in) else $error("early pulse mode");
	property p_uni; $rose(input_mode_out == 2'(MODE_UNIPOLAR)) |-> neg_run >= 17; endproperty
	a_uni: assert property (p_uni) else $error("early data mode");
	c_rz: cover property (input_mode_out == 2'(MODE_RZ));
	c_uni: cover property (input_mode_out == 2'(MODE_UNIPOLAR));
	c_clr: cover property ($fell(signal_loss_out));
endmodule : e1_tx_input_checker

bind e1_tx_input e1_tx_input_checker #(.RZ_ENTRY_CYCLES(RZ_ENTRY_CYCLES),
	.LOS_ZEROS_ETSI(LOS_ZEROS_ETSI), .LOS_ONES_ETSI(LOS_ONES_ETSI)) i_e1_tx_input_checker (
	.core_clk, .rstn, .tx_bit_clock_in, .tx_positive_pulse_in, .tx_negative_pulse_in,
	.master_clock_present, .los_standard_etsi, .rx_pulse_in, .signal_loss_out,
	.line_tx_tip, .line_tx_ring, .line_tx_oe_n, .input_mode_out);

/* File: verif/tb_e1_tx_input.sv */
// Purpose: Bench for the E1 transmit input block.
// Assumes: Framer model drives the bit clock.
// Notes:   Short entry and ETSI counts.
module tb_e1_tx_input
	import e1_tx_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int RZ_N = 40;
	localparam int ET_N = 8;
	logic         core_clk = 1'b0;
	logic         rstn = 1'b0;
	logic         master_clock_present = 1'b1;
	logic         los_standard_etsi = 1'b0;
	logic         rx_pulse_in = 1'b0;
	logic         run = 1'b1;
	logic         park_hi = 1'b0;
	line_symbol_s sym = '0;
	logic         tx_bit_clock_in, tx_positive_pulse_in, tx_negative_pulse_in;
	logic         signal_loss_out, line_tx_tip, line_tx_ring, line_tx_oe_n;
	logic [1:0]   input_mode_out;
	int           error_cnt = 0;
	int           tests_run = 0;
	always #2.5 core_clk = !core_clk;
	e1_tx_input #(.RZ_ENTRY_CYCLES(RZ_N), .LOS_ZEROS_ETSI(ET_N), .LOS_ONES_ETSI(ET_N))
		i_e1_tx_input (.core_clk, .rstn, .tx_bit_clock_in, .tx_positive_pulse_in,
		.tx_negative_pulse_in, .master_clock_present, .los_standard_etsi, .rx_pulse_in,
		.signal_loss_out, .line_tx_tip, .line_tx_ring, .line_tx_oe_n, .input_mode_out);
	e1_framer_model i_e1_framer_model (.run, .park_hi, .sym, .bclk(tx_bit_clock_in),
		.pos(tx_positive_pulse_in), .neg(tx_negative_pulse_in));
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask : cyc
	// Bounded wait for a falling bit clock, polled on core_clk
	task automatic bit_fall();
		logic was;
		int   k;
		was = tx_bit_clock_in;
		for (k = 0; k < 100; k++) begin
			@(negedge core_clk);
			if (was && !tx_bit_clock_in) break;
			was = tx_bit_clock_in;
		end
		if (k == 100) begin
			error_cnt++;
			tally_and_finish();
		end
	endtask : bit_fall
	// Two bits: old symbol once more, then s; output shows the old one
	task automatic send(input line_symbol_s s);
		bit_fall();
		cyc(10);
		sym = s;
		bit_fall();
		cyc(10);
	endtask : send
	function automatic logic [1:0] mark(input line_symbol_s s);
		return {s.pos & !s.neg, s.neg & !s.pos};
	endfunction : mark
	task automatic t_bipolar();
		line_symbol_s tab [6] = '{2'b10, 2'b01, 2'b11, 2'b00, 2'b01, 2'b10};
		line_symbol_s prev;
		prev = sym;
		foreach (tab[i]) begin
			send(tab[i]);
			chk({line_tx_oe_n, line_tx_tip, line_tx_ring}, {1'b0, mark(prev)});
			prev = tab[i];
		end
	endtask : t_bipolar
	// Parked low long enough to release, then restart
	task automatic t_hiz();
		run = 1'b0;
		cyc(300);
		chk({line_tx_oe_n, line_tx_tip, line_tx_ring}, 3'h4);
		run = 1'b1;
		send(sym);
		chk(line_tx_oe_n, 1'b0);
	endtask : t_hiz
	// Parked high, no master clock: widths must pass through
	task automatic t_rz();
		int wt;
		int wr;
		{wt, wr} = '0;
		sym = '0;
		master_clock_present = 1'b0;
		park_hi = 1'b1;
		run = 1'b0;
		cyc(RZ_N + 60);
		chk(input_mode_out, 2'(MODE_RZ));
		for (int i = 0; i < 40; i++) begin
			sym = (i < 7) ? 2'b10 : ((i > 14 && i < 26) ? 2'b01 : 2'b00);
			cyc(1);
			wt += line_tx_tip;
			wr += line_tx_ring;
		end
		chk(8'(wt), 8'h07);
		chk(8'(wr), 8'h0B);
		master_clock_present = 1'b1;
		cyc(10);
		chk(input_mode_out, 2'(MODE_BIPOLAR));
		{run, park_hi} = 2'b10;
		cyc(400);
	endtask : t_rz
	// Threshold minus two holds the flag, plus four flips it
	task automatic t_los(input int n, input logic etsi);
		los_standard_etsi = etsi;
		rx_pulse_in = 1'b1;
		cyc((n - 2) * 32);
		chk(signal_loss_out, 1'b1);
		cyc(6 * 32);
		chk(signal_loss_out, 1'b0);
		rx_pulse_in = 1'b0;
		cyc((n - 2) * 32);
		chk(signal_loss_out, 1'b0);
		cyc(6 * 32);
		chk(signal_loss_out, 1'b1);
	endtask : t_los
	// Select high past the count, then data on the positive pin
	task automatic t_uni();
		repeat (10) send(2'b01);
		chk(input_mode_out, 2'(MODE_UNIPOLAR));
		send(2'b11);
		send(2'b01);
		chk({line_tx_tip, line_tx_ring}, 2'b10);
		send(2'b11);
		chk({line_tx_tip, line_tx_ring}, 2'b00);
	endtask : t_uni
	initial begin
		cyc(12);
		chk({signal_loss_out, line_tx_oe_n, input_mode_out}, 4'hC);
		rstn = 1'b1;
		cyc(40);
		t_bipolar();
		t_hiz();
		t_rz();
		t_los(32, 1'b0);
		t_los(ET_N, 1'b1);
		t_uni();
		tally_and_finish();
	end
	// Hang guard
	initial begin
		repeat (100000) @(posedge core_clk);
		error_cnt++;
		tally_and_finish();
	end
endmodule : tb_e1_tx_input
